/* design/rav_pkg.sv */
// Summary of operation
// - any read of alarm window high or low byte decrements the alarm pointer
// - any read of timer window high or low byte decrements the timer pointer
// - writes to the window low byte never decrement a pointer
// - timer value writes are dropped unless timer_write_enable (bit 13) is set
// - timer_write_enable can be set only by the next transfer after key 55h then aah
// - weekday/hours holds weekday 0..6 in bits 10-8; bits 15-11 unused
// - hour tens in bits 5-4, hour ones in bits 3-0; bits 7-6 unused
// - unimplemented alarm bits read zero; alarm fields cleared to zero by reset
// - minute tens in bits 14-12, minute ones in 11-8; bit 15 unused
// - second tens in bits 6-4, second ones in 3-0; bit 7 unused
// - alarm minutes/seconds writes accepted only while write enable is one
// - mask 0000 half second, 0001 second, 0010 ten seconds, 0011 minute
// - mask 0100 ten minutes, 0101 hour, 0110 day
// - mask 0111 week, 1000 month, 1001 year; feb 29 not yearly
// - alarm pointer bits 9:8 picks min/sec, alarm_weekday_field/hour, month/day, none
// - writing the window high byte decrements the pointer, stopping at 00
package rav_pkg;
   // byte addresses on the ahb-lite slave
   localparam logic [7:0] ADDR_CFG = 8'h00;   // clock_config_calibration
   localparam logic [7:0] ADDR_TWIN = 8'h04;  // timer window
   localparam logic [7:0] ADDR_ACFG = 8'h08;  // alarm_config_repeat
   localparam logic [7:0] ADDR_AWIN = 8'h0c;  // alarm window
   localparam logic [7:0] ADDR_KEY = 8'h10;   // unlock key
   localparam logic [7:0] ADDR_STAT = 8'h14;  // interrupt status, w1c
   localparam logic [7:0] ADDR_MASK = 8'h18;  // interrupt mask
   localparam logic [7:0] ADDR_TIME = 8'h1c;  // current time inputs, ro
   // field positions
   localparam int WREN_BIT = 13;
   localparam int PTR_LO = 8;
   localparam int ALARM_REPEAT_MASK_LO = 10;
   localparam int ALRMEN_BIT = 15;
   localparam logic [7:0] KEY1 = 8'h55;
   localparam logic [7:0] KEY2 = 8'haa;
   // implemented bits of the alarm pair registers
   localparam logic [15:0] WDHR_MASK = 16'h073f;
   localparam logic [15:0] MINSEC_MASK = 16'h7f7f;
   localparam logic [15:0] MDAY_MASK = 16'h1f3f;
   localparam logic [1:0] PTR_MINSEC = 2'h0;
   localparam logic [1:0] PTR_WDHR = 2'h1;
   localparam logic [1:0] PTR_MDAY = 2'h2;
   localparam logic [1:0] PTR_NONE = 2'h3;
   localparam logic [3:0] AM_HALF = 4'h0;
   localparam logic [3:0] AM_SEC = 4'h1;
   localparam logic [3:0] AM_10S = 4'h2;
   localparam logic [3:0] AM_MIN = 4'h3;
   localparam logic [3:0] AM_10M = 4'h4;
   localparam logic [3:0] AM_HOUR = 4'h5;
   localparam logic [3:0] AM_DAY = 4'h6;
   localparam logic [3:0] AM_WEEK = 4'h7;
   localparam logic [3:0] AM_MONTH = 4'h8;
   localparam logic [3:0] AM_YEAR = 4'h9;
   localparam logic [15:0] FEB29 = 16'h0229;
   localparam int NUM_EV = 2;
   localparam int EV_ALARM = 0;
   localparam int EV_LOCKWR = 1;

   typedef enum logic [1:0] {
      RAV_KEY_IDLE,
      RAV_KEY_GOT55,
      RAV_KEY_OPEN
   } rav_key_e;

   // current calendar time from the counting part, bcd
   typedef struct packed {
      logic [15:0] minsec;
      logic [15:0] wdhr;
      logic [15:0] mday;
      logic half;  // second half marker
   } rav_time_s;

   typedef struct packed {
      logic [31:0] hrdata;
      logic hreadyout;
      logic dph_act;
      logic dph_wr;
      logic [7:0] dph_addr;
      logic [3:0] dph_strb;
      logic wren;
      logic [1:0] tptr;
      logic [1:0] aptr;
      logic [3:0] alarm_repeat_mask;
      logic alrm_en;
      logic [15:0] al_minsec;
      logic [15:0] al_wdhr;
      logic [15:0] al_mday;
      logic [15:0] t_minsec;
      logic [15:0] t_wdhr;
      logic [15:0] t_mday;
      logic t_load;
      rav_key_e key;
      logic [NUM_EV-1:0] stat;
      logic [NUM_EV-1:0] imask;
      logic irq;
      logic alarm_pulse;
      logic [15:0] match_q;
   } rav_state_s;
endpackage : rav_pkg

/* design/rav_top.sv */
`timescale 1ns/1ns
module rav_top (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // calendar counter side
   input wire rav_pkg::rav_time_s cur_time,
   output logic [15:0] load_minsec,
   output logic [15:0] load_wdhr,
   output logic [15:0] load_mday,
   output logic load_time,
   // alarm and interrupt
   output logic alarm_pulse,
   output logic irq
);
   import rav_pkg::*;

   rav_state_s s_ff;
   rav_state_s nxt_s;
   logic [15:0] wsel;
   logic [15:0] asel;
   logic [15:0] tsel;
   logic [15:0] wr_hw;
   logic acc_hi;
   logic [NUM_EV-1:0] ev;
   logic matched;
   logic edge_ok;
   logic rd_t;
   logic rd_a;

   // pointer decrement, saturating at 00
   function automatic logic [1:0] dec_sat(input logic [1:0] p);
      dec_sat = (p == PTR_MINSEC) ? PTR_MINSEC : p - 2'h1;
   endfunction : dec_sat

   // pick the pair word behind a pointer
   function automatic logic [15:0] pick(input logic [1:0] p,
         input logic [15:0] ms, input logic [15:0] wh,
         input logic [15:0] md);
      unique case (p)
         PTR_MINSEC: pick = ms;
         PTR_WDHR: pick = wh;
         PTR_MDAY: pick = md;
         PTR_NONE: pick = 16'h0000;
      endcase
   endfunction : pick

   // mask-dependent compare; coarser fields are ignored
   always_comb begin
      logic [15:0] ms_m;
      logic [15:0] wh_m;
      logic [15:0] md_m;
      ms_m = 16'h0000;
      wh_m = 16'h0000;
      md_m = 16'h0000;
      unique case (s_ff.alarm_repeat_mask)
         AM_HALF, AM_SEC: ms_m = 16'h0000;
         AM_10S: ms_m = 16'h000f;
         AM_MIN: ms_m = 16'h007f;
         AM_10M: ms_m = 16'h0f7f;
         AM_HOUR: ms_m = MINSEC_MASK;
         AM_DAY: begin
            ms_m = MINSEC_MASK;
            wh_m = 16'h003f;
         end
         AM_WEEK: begin
            ms_m = MINSEC_MASK;
            wh_m = WDHR_MASK;
         end
         AM_MONTH: begin
            ms_m = MINSEC_MASK;
            wh_m = 16'h003f;
            md_m = 16'h003f;
         end
         AM_YEAR: begin
            ms_m = MINSEC_MASK;
            wh_m = 16'h003f;
            md_m = MDAY_MASK;
         end
         default: ms_m = 16'hffff; // illegal code compares every minsec bit; the range check below blocks the match
      endcase
      matched = ((cur_time.minsec & ms_m) == (s_ff.al_minsec & ms_m))
         && ((cur_time.wdhr & wh_m) == (s_ff.al_wdhr & wh_m))
         && ((cur_time.mday & md_m) == (s_ff.al_mday & md_m))
         && !(s_ff.alarm_repeat_mask > AM_YEAR);
   end

   // half-second mode fires on each half tick, others on a new second
   assign edge_ok = (s_ff.alarm_repeat_mask == AM_HALF)
      ? (cur_time.half != s_ff.match_q[15])
      : (cur_time.minsec[6:0] != s_ff.match_q[6:0]);

   // current window words for the write merge, unimplemented alarm bits already zero
   assign asel = pick(s_ff.aptr, s_ff.al_minsec, s_ff.al_wdhr,
      s_ff.al_mday);
   assign tsel = pick(s_ff.tptr, cur_time.minsec, cur_time.wdhr,
      cur_time.mday);
   assign acc_hi = s_ff.dph_strb[1];
   assign rd_t = s_ff.dph_act && !s_ff.dph_wr && s_ff.dph_addr == ADDR_TWIN;
   assign rd_a = s_ff.dph_act && !s_ff.dph_wr && s_ff.dph_addr == ADDR_AWIN;

   // byte-lane merge of a write into the selected pair
   always_comb begin
      wsel = (s_ff.dph_addr == ADDR_AWIN) ? asel : tsel;
      wr_hw = wsel;
      if (s_ff.dph_strb[0]) begin
         wr_hw[7:0] = hwdata[7:0];
      end
      if (s_ff.dph_strb[1]) begin
         wr_hw[15:8] = hwdata[15:8];
      end
   end

   // whole next state
   always_comb begin
      logic [31:0] rd;
      logic [7:0] ap_word;
      nxt_s = s_ff;
      rd = 32'h0000_0000;
      // word decode, so a byte access to either window half still hits it
      ap_word = {haddr[7:2], 2'h0};
      ev = '0;
      nxt_s.hreadyout = 1'b1;
      nxt_s.t_load = 1'b0;
      nxt_s.alarm_pulse = 1'b0;
      nxt_s.match_q = {cur_time.half, 8'h00, cur_time.minsec[6:0]};
      // key sequence: the next transfer of any kind closes it, so idle
      // cycles between the key writes and the enable write are harmless
      unique case (s_ff.key)
         RAV_KEY_IDLE: nxt_s.key = RAV_KEY_IDLE;
         RAV_KEY_GOT55, RAV_KEY_OPEN: begin
            if (s_ff.dph_act) begin
               nxt_s.key = RAV_KEY_IDLE;
            end
         end
      endcase
      // data phase of a write
      if (s_ff.dph_act && s_ff.dph_wr) begin
         unique case (s_ff.dph_addr)
            ADDR_KEY: begin
               if (hwdata[7:0] == KEY1) begin
                  nxt_s.key = RAV_KEY_GOT55;
               end else if (hwdata[7:0] == KEY2
                     && s_ff.key == RAV_KEY_GOT55) begin
                  nxt_s.key = RAV_KEY_OPEN;
               end
            end
            ADDR_CFG: begin
               nxt_s.tptr = hwdata[PTR_LO +: 2];
               // clearing is always allowed, setting only when open
               if (!hwdata[WREN_BIT]) begin
                  nxt_s.wren = 1'b0;
               end else if (s_ff.key == RAV_KEY_OPEN) begin
                  nxt_s.wren = 1'b1;
               end
            end
            ADDR_ACFG: begin
               nxt_s.aptr = hwdata[PTR_LO +: 2];
               nxt_s.alarm_repeat_mask = hwdata[ALARM_REPEAT_MASK_LO +: 4];
               nxt_s.alrm_en = hwdata[ALRMEN_BIT];
            end
            ADDR_TWIN: begin
               if (s_ff.wren) begin
                  nxt_s.t_load = s_ff.tptr != PTR_NONE;
                  nxt_s.t_minsec = cur_time.minsec;
                  nxt_s.t_wdhr = cur_time.wdhr;
                  nxt_s.t_mday = cur_time.mday;
                  unique case (s_ff.tptr)
                     PTR_MINSEC: nxt_s.t_minsec = wr_hw;
                     PTR_WDHR: nxt_s.t_wdhr = wr_hw;
                     PTR_MDAY: nxt_s.t_mday = wr_hw;
                     PTR_NONE: nxt_s.t_load = 1'b0;
                  endcase
               end else begin
                  ev[EV_LOCKWR] = 1'b1;
               end
               if (acc_hi) begin
                  nxt_s.tptr = dec_sat(s_ff.tptr);
               end
            end
            ADDR_AWIN: begin
               if (s_ff.wren) begin
                  unique case (s_ff.aptr)
                     PTR_MINSEC: nxt_s.al_minsec = wr_hw & MINSEC_MASK;
                     PTR_WDHR: nxt_s.al_wdhr = wr_hw & WDHR_MASK;
                     PTR_MDAY: nxt_s.al_mday = wr_hw & MDAY_MASK;
                     PTR_NONE: nxt_s.al_mday = s_ff.al_mday;
                  endcase
               end else begin
                  ev[EV_LOCKWR] = 1'b1;
               end
               if (acc_hi) begin
                  nxt_s.aptr = dec_sat(s_ff.aptr);
               end
            end
            ADDR_STAT: nxt_s.stat = s_ff.stat & ~hwdata[NUM_EV-1:0];
            ADDR_MASK: nxt_s.imask = hwdata[NUM_EV-1:0];
            default: nxt_s.imask = s_ff.imask;
         endcase
      end
      // reads of either byte decrement the pointer
      if (rd_t) begin
         nxt_s.tptr = dec_sat(s_ff.tptr);
      end
      if (rd_a) begin
         nxt_s.aptr = dec_sat(s_ff.aptr);
      end
      // alarm detection; feb 29 yearly alarms fire only while the time shows feb 29
      if (s_ff.alrm_en && matched && edge_ok
            && !(s_ff.alarm_repeat_mask == AM_YEAR && s_ff.al_mday == FEB29
            && cur_time.mday != FEB29)) begin
         nxt_s.alarm_pulse = 1'b1;
         ev[EV_ALARM] = 1'b1;
      end
      // sticky status; set wins over a same-cycle clear
      nxt_s.stat = nxt_s.stat | ev;
      nxt_s.irq = |(nxt_s.stat & nxt_s.imask);
      // address phase capture, read data set up for the next phase
      nxt_s.dph_act = hsel && hready && htrans[1];
      nxt_s.dph_wr = hwrite;
      nxt_s.dph_addr = ap_word; // lanes are kept apart in dph_strb
      nxt_s.dph_strb = 4'hf;
      if (hsize == 3'h0) begin
         nxt_s.dph_strb = 4'h1 << haddr[1:0];
      end else if (hsize == 3'h1) begin
         nxt_s.dph_strb = haddr[1] ? 4'hc : 4'h3;
      end
      unique case (ap_word)
         ADDR_CFG: begin
            rd[WREN_BIT] = nxt_s.wren;
            rd[PTR_LO +: 2] = nxt_s.tptr;
         end
         ADDR_TWIN: rd[15:0] = pick(nxt_s.tptr, cur_time.minsec,
            cur_time.wdhr, cur_time.mday);
         ADDR_ACFG: begin
            rd[PTR_LO +: 2] = nxt_s.aptr;
            rd[ALARM_REPEAT_MASK_LO +: 4] = nxt_s.alarm_repeat_mask;
            rd[ALRMEN_BIT] = nxt_s.alrm_en;
         end
         ADDR_AWIN: rd[15:0] = pick(nxt_s.aptr, nxt_s.al_minsec,
            nxt_s.al_wdhr, nxt_s.al_mday);
         ADDR_STAT: rd[NUM_EV-1:0] = nxt_s.stat;
         ADDR_MASK: rd[NUM_EV-1:0] = nxt_s.imask;
         ADDR_TIME: rd[15:0] = cur_time.minsec;
         default: rd = 32'h0000_0000;
      endcase
      nxt_s.hrdata = rd;
   end

   // reset clears the state except hreadyout, which it sets to one, alarm value fields included
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s_ff <= '0;
         s_ff.hreadyout <= 1'b1;
         s_ff.key <= RAV_KEY_IDLE;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // outputs straight from the state register, hresp tied to okay
   assign hrdata = s_ff.hrdata;
   assign hreadyout = s_ff.hreadyout;
   assign hresp = 1'b0;
   assign load_minsec = s_ff.t_minsec;
   assign load_wdhr = s_ff.t_wdhr;
   assign load_mday = s_ff.t_mday;
   assign load_time = s_ff.t_load;
   assign alarm_pulse = s_ff.alarm_pulse;
   assign irq = s_ff.irq;
endmodule : rav_top

/* testbench/rav_checker.sv */
`timescale 1ns/1ns
module rav_checker (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // ahb-lite
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // events
   input wire logic load_time,
   input wire logic alarm_pulse,
   input wire logic irq
);
   import rav_pkg::*;
   logic ap_rd;
   logic ap_wr;
   logic [3:0] since_wr_ff;
   logic [3:0] nxt_since_wr;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);
   // address phases taken by the slave
   assign ap_rd = hsel && hready && htrans[1] && !hwrite;
   assign ap_wr = hsel && hready && htrans[1] && hwrite;
   // age of the last write, saturating so it never wraps to fresh
   always_comb begin
      nxt_since_wr = since_wr_ff;
      if (ap_wr) begin
         nxt_since_wr = 4'h0;
      end else if (since_wr_ff != 4'hf) begin
         nxt_since_wr = since_wr_ff + 4'h1;
      end
   end
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         since_wr_ff <= 4'hf;
      end else begin
         since_wr_ff <= nxt_since_wr;
      end
   end
   resp_okay_a: assert property (hresp == 1'b0)
      else $error("hresp not okay");
   zero_wait_a: assert property (hreadyout == 1'b1)
      else $error("wait state inserted");
   read_upper_a: assert property (ap_rd |=> hrdata[31:16] == 16'h0)
      else $error("upper read half not zero");
   unmapped_zero_a: assert property (ap_rd && haddr[7:0] > 8'h1f
      |=> hrdata == 32'h0) else $error("unmapped read not zero");
   alarm_unused_a: assert property (
      ap_rd && haddr[7:0] == ADDR_AWIN |=> !hrdata[15] && !hrdata[7])
      else $error("unused alarm bit set");
   load_cause_a: assert property (load_time |->
      $past(ap_wr, 2) && $past(haddr[7:2], 2) == ADDR_TWIN[7:2])
      else $error("load without timer write");
   pulse_single_a: assert property (alarm_pulse |=> !alarm_pulse)
      else $error("alarm pulse too long");
   irq_fall_a: assert property ($fell(irq) |-> since_wr_ff <= 4'h4)
      else $error("irq dropped without write");
   irq_rise_a: assert property ($rose(irq) |-> since_wr_ff <= 4'h4
      || alarm_pulse || $past(alarm_pulse) || $past(alarm_pulse, 2))
      else $error("irq raised without cause");
endmodule : rav_checker

bind rav_top rav_checker i_chk (.mclk(mclk), .arst_n(arst_n),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .load_time(load_time), .alarm_pulse(alarm_pulse),
   .irq(irq));

/* testbench/tb.sv */
`timescale 1ns/1ns
module tb;
   import rav_pkg::*;
   logic mclk, arst_n, hsel, hwrite, hreadyout, hresp;
   logic load_time, alarm_pulse, irq;
   logic [31:0] haddr, hwdata, hrdata, v;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [15:0] load_minsec, load_wdhr, load_mday;
   logic [15:0] last_ms, last_wh, last_md;
   logic [47:0] x, t;
   rav_time_s cur_time;
   int n_errors = 0, checked = 0, cyc = 0, n_load = 0, n_pulse = 0;
   // fields compared for each repeat code, {mday, wdhr, minsec}
   logic [47:0] cmp [10] = '{48'h0, 48'h0, 48'hf, 48'h7f, 48'hf7f,
      48'h7f7f, 48'h3f7f7f, 48'h73f7f7f, 48'h3f003f7f7f, 48'h1f3f003f7f7f};

   rav_top i_dut (.mclk(mclk), .arst_n(arst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .cur_time(cur_time),
      .load_minsec(load_minsec), .load_wdhr(load_wdhr),
      .load_mday(load_mday),
      .load_time(load_time), .alarm_pulse(alarm_pulse), .irq(irq));

   // free running clock
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // event counters and hang guard
   always @(posedge mclk) begin
      cyc++;
      if (load_time === 1'b1) begin
         n_load++;
         last_ms = load_minsec;
         last_wh = load_wdhr;
         last_md = load_mday;
      end
      if (alarm_pulse === 1'b1) n_pulse++;
      if (cyc == 20000) begin
         n_errors++;
         test_done;
      end
   end

   task test_done;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // bounded wait for hready sampled high at a rising edge
   task wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      if (hreadyout !== 1'b1) begin
         n_errors++;
         test_done;
      end
   endtask : wait_rdy

   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [2:0] sz, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      hsize <= sz;
      wait_rdy;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy;
      rd = hrdata;
   endtask : xfer

   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 3'd2, v);
   endtask : wr

   task rdc(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0, 3'd2, v);
      chk(v, exp);
   endtask : rdc

   task unlock(input logic [31:0] cfg);
      wr(ADDR_KEY, {24'h0, KEY1});
      wr(ADDR_KEY, {24'h0, KEY2});
      wr(ADDR_CFG, cfg);
   endtask : unlock

   // irq is registered behind status, so let it land
   task settle;
      repeat (3) @(posedge mclk);
   endtask : settle

   // step the time so seconds change into t, count alarm pulses
   task run(input logic [47:0] tt, input logic [31:0] exp);
      cur_time <= '{minsec: tt[15:0] ^ 16'h0010, wdhr: tt[31:16],
         mday: tt[47:32], half: 1'b0};
      repeat (4) @(posedge mclk);
      n_pulse = 0;
      cur_time <= '{minsec: tt[15:0], wdhr: tt[31:16],
         mday: tt[47:32], half: 1'b1};
      repeat (6) @(posedge mclk);
      chk(n_pulse, exp);
   endtask : run

   // main sequence
   initial begin
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'd2;
      cur_time = '0;
      arst_n = 1'b0;
      repeat (12) @(posedge mclk);
      arst_n <= 1'b1;
      @(posedge mclk);
      chk(irq, 1'b0);
      unlock(32'h2000);
      rdc(ADDR_CFG, 32'h2000);
      wr(ADDR_ACFG, 32'h0);
      wr(ADDR_AWIN, 32'h5959);
      rdc(ADDR_AWIN, 32'h5959);
      rdc(ADDR_AWIN, 32'h5959);
      wr(ADDR_ACFG, 32'h100);
      wr(ADDR_AWIN, 32'hffffffff);
      rdc(ADDR_AWIN, 32'h5959);
      wr(ADDR_ACFG, 32'h100);
      rdc(ADDR_AWIN, {16'h0, WDHR_MASK});
      rdc(ADDR_ACFG, 32'h0);
      wr(ADDR_ACFG, 32'h100);
      xfer(1'b1, ADDR_AWIN, 32'h12, 3'd0, v);
      rdc(ADDR_ACFG, 32'h100);
      rdc(ADDR_AWIN, 32'h0712);
      wr(ADDR_ACFG, 32'h300);
      rdc(ADDR_AWIN, 32'h0);
      xfer(1'b0, ADDR_AWIN + 8'h1, 32'h0, 3'd0, v);
      rdc(ADDR_ACFG, 32'h100);
      wr(ADDR_CFG, 32'h100);
      xfer(1'b0, ADDR_TWIN, 32'h0, 3'd2, v);
      rdc(ADDR_CFG, 32'h0);
      // write enable now clear: both windows must refuse
      wr(ADDR_ACFG, 32'h0);
      wr(ADDR_AWIN, 32'h0101);
      rdc(ADDR_AWIN, 32'h5959);
      wr(ADDR_TWIN, 32'h1111);
      chk(n_load, 0);
      rdc(ADDR_STAT, 32'h2);
      chk(irq, 1'b0);
      wr(ADDR_MASK, 32'h2);
      settle;
      chk(irq, 1'b1);
      wr(ADDR_STAT, 32'h2);
      settle;
      chk(irq, 1'b0);
      rdc(ADDR_STAT, 32'h0);
      wr(ADDR_KEY, {24'h0, KEY1});
      wr(ADDR_KEY, {24'h0, KEY2});
      rdc(ADDR_ACFG, 32'h0);
      wr(ADDR_CFG, 32'h2000);
      rdc(ADDR_CFG, 32'h0);
      unlock(32'h2000);
      // untouched words of the load come from the running time
      cur_time <= '{minsec: 16'h0102, wdhr: 16'h0623, mday: 16'h1231,
         half: 1'b0};
      wr(ADDR_TWIN, 32'h1234);
      settle;
      chk(n_load, 1);
      chk(last_ms, 16'h1234);
      chk({last_md, last_wh}, 32'h1231_0623);
      rdc(ADDR_TIME, 32'h0102);
      wr(ADDR_ACFG, 32'h200);
      repeat (3) wr(ADDR_AWIN, 32'h0);
      rdc(ADDR_ACFG, 32'h0);
      wr(ADDR_CFG, 32'h0);
      for (int m = 0; m < 10; m++) begin
         wr(ADDR_ACFG, 32'h8000 | (m << 10));
         x = (m >= 2) ? (cmp[m] & ~cmp[m-1]) : 48'h1;
         t = 48'h12310623_5958 & ~cmp[m];
         run(t, 1);
         run(t ^ (x & (~x + 48'h1)), (m < 2) ? 1 : 0);
      end
      rdc(ADDR_STAT, 32'h1);
      rdc(8'h20, 32'h0);
      test_done;
   end
endmodule : tb
